//--- hdl/pls_defs.svh
// register offsets, field positions and timing constants of the port speed and idle control
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH

`define PLS_OFS_LINK_CTL      8'h68
`define PLS_OFS_LINK_CTL_TWO  8'h88
`define PLS_OFS_IDLE_TIMER    8'hA0
`define PLS_OFS_SPEED_CFG     8'hA4

`define PLS_BIT_L0S_EN        0
`define PLS_BIT_RETRAIN       5
`define PLS_BIT_FAST_EN       0
`define PLS_BIT_KICK          7
`define PLS_BIT_PARTNER_FAST  24
`define PLS_TGT_LSB           0
`define PLS_TGT_MSB           3
`define PLS_TMR_LSB           8
`define PLS_TMR_MSB           11

`define PLS_TGT_GEN1          4'h1
`define PLS_TGT_GEN2          4'h2
`define PLS_TMR_40NS          4'h1
`define PLS_TMR_RESET         4'h0
`define PLS_LINK_CTL_RESET    16'h0000
`define PLS_IDLE_CFG_RESET    32'h00000000
`define PLS_SPEED_CFG_RESET   32'h00000000

`define PLS_CLK_PERIOD_NS     8
`define PLS_IDLE_STEP_NS      40
`define PLS_IDLE_STEP_CYC     ((`PLS_IDLE_STEP_NS + `PLS_CLK_PERIOD_NS - 1) / `PLS_CLK_PERIOD_NS)

`define PLS_AXI_OFS_CTRL      8'h00
`define PLS_AXI_OFS_STATUS    8'h04
`define PLS_CTRL_GO_SPEED     0
`define PLS_CTRL_GO_L0S       1
`define PLS_CTRL_ALT_KICK     2
`define PLS_CTRL_HOT_PLUG     3
`define PLS_CTRL_RX_BAD       4
`define PLS_CTRL_TX_BAD       5
`define PLS_ST_BUSY           0
`define PLS_ST_SPEED_DONE     1
`define PLS_ST_SPEED_ABANDON  2
`define PLS_ST_L0S_DONE       3
`define PLS_ST_L0S_SKIPPED    4
`define PLS_RESP_OKAY         2'h0
`define PLS_RESP_SLVERR       2'h2

`endif

//--- hdl/pls_pkg.sv
// types shared by both ends of the port speed and idle control
`default_nettype none
package pls_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CAP_RD, ST_TGT_WR, ST_HWEN_WR, ST_LC_RD, ST_KICK_WR, ST_TMR_WR, ST_LC2_RD, ST_L0S_WR
  } pls_state_t;
endpackage : pls_pkg
`default_nettype wire

//--- hdl/pls_link_if.sv
// register access channel between the controller and the port register bank
`timescale 1ns/1ps
`default_nettype none
interface pls_link_if;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  modport ctl (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : pls_link_if
`default_nettype wire

//--- hdl/pls_port_regs.sv
// root port register bank: speed upgrade controls and transmitter idle entry
`timescale 1ns/1ps
`default_nettype none
`include "pls_defs.svh"
module pls_port_regs
  import pls_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  pls_link_if.dev        link,
  input  wire logic      partner_fast_capable,
  input  wire logic      tx_busy,
  output logic           fast_speed_hw_enable,
  output logic [3:0]     target_speed,
  output logic           speed_change_kick,
  output logic [3:0]     tx_idle_entry_timer,
  output logic           tx_l0s_allow,
  output logic           tx_l0s_enter
);
  logic [15:0] link_ctl_reg;
  logic [15:0] link_ctl_two_reg;
  logic [31:0] idle_cfg_reg;
  logic [31:0] speed_cfg_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        kick_reg;
  logic [7:0]  idle_cnt_reg;
  logic        enter_reg;
  logic        take;
  logic [7:0]  idle_limit;

  assign take       = link.req && !ack_reg;
  assign idle_limit = 8'(idle_cfg_reg[`PLS_TMR_MSB:`PLS_TMR_LSB]) * 8'(`PLS_IDLE_STEP_CYC);
  assign link.ack   = ack_reg;
  assign link.rdata = rdata_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= take;
    end
  end

  // register writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_ctl_reg     <= `PLS_LINK_CTL_RESET;
      // R15 trains at first speed
      link_ctl_two_reg <= {12'h000, `PLS_TGT_GEN1};
      idle_cfg_reg     <= `PLS_IDLE_CFG_RESET;
      speed_cfg_reg    <= `PLS_SPEED_CFG_RESET;
    end else if (take && link.we) begin
      case (link.addr)
        // R9 transmitter idle permission
        `PLS_OFS_LINK_CTL:     link_ctl_reg <= link.wdata[15:0] & ~(16'h0001 << `PLS_BIT_RETRAIN);
        // R3 target speed field
        `PLS_OFS_LINK_CTL_TWO: link_ctl_two_reg <= link.wdata[15:0];
        // R8 idle timer field
        `PLS_OFS_IDLE_TIMER:   idle_cfg_reg <= link.wdata;
        // R4 fast hardware enable
        `PLS_OFS_SPEED_CFG:    speed_cfg_reg <= link.wdata & ~((32'h1 << `PLS_BIT_KICK) | (32'h1 << `PLS_BIT_PARTNER_FAST));
        default:               link_ctl_reg <= link_ctl_reg;
      endcase
    end
  end

  // register reads
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else if (take && !link.we) begin
      case (link.addr)
        `PLS_OFS_LINK_CTL:     rdata_reg <= {16'h0000, link_ctl_reg};
        `PLS_OFS_LINK_CTL_TWO: rdata_reg <= {16'h0000, link_ctl_two_reg};
        `PLS_OFS_IDLE_TIMER:   rdata_reg <= idle_cfg_reg;
        // R1 partner capability readable
        `PLS_OFS_SPEED_CFG:    rdata_reg <= speed_cfg_reg | (32'(partner_fast_capable) << `PLS_BIT_PARTNER_FAST);
        default:               rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // R5 R6 R16 one kick per write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kick_reg <= 1'b0;
    end else begin
      kick_reg <= take && link.we &&
                  (((link.addr == `PLS_OFS_LINK_CTL) && link.wdata[`PLS_BIT_RETRAIN]) ||
                   ((link.addr == `PLS_OFS_SPEED_CFG) && link.wdata[`PLS_BIT_KICK]));
    end
  end

  // R8 R9 idle counter for entry
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= 8'h00;
      enter_reg    <= 1'b0;
    end else if (tx_busy || !link_ctl_reg[`PLS_BIT_L0S_EN] || (idle_limit == 8'h00)) begin
      idle_cnt_reg <= 8'h00;
      enter_reg    <= 1'b0;
    end else if (idle_cnt_reg != idle_limit) begin
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end else begin
      enter_reg <= 1'b1;
    end
  end

  assign fast_speed_hw_enable = speed_cfg_reg[`PLS_BIT_FAST_EN];
  assign target_speed         = link_ctl_two_reg[`PLS_TGT_MSB:`PLS_TGT_LSB];
  assign speed_change_kick    = kick_reg;
  assign tx_idle_entry_timer  = idle_cfg_reg[`PLS_TMR_MSB:`PLS_TMR_LSB];
  assign tx_l0s_allow         = link_ctl_reg[`PLS_BIT_L0S_EN];
  assign tx_l0s_enter         = enter_reg;
endmodule : pls_port_regs
`default_nettype wire

//--- hdl/pls_fw_ctl.sv
// controller end: runs the speed upgrade and idle enable sequences, ordered over AXI4-Lite
// Summary of operation
// R1 - port reports partner fast capability bit
// R2 - abandon upgrade when partner lacks capability
// R3 - target speed field, value two selects fast
// R4 - fast hardware enabled only by enable bit
// R5 - retrain bit write launches speed change
// R6 - alternate kick bit launches speed change
// R7 - capability, target, enable, then trigger order
// R8 - idle timer field, one means forty ns
// R9 - idle entry allowed only by enable bit
// R10 - check partner L0s support before enabling
// R11 - enable partner transmitter idle when capable
// R12 - clear port enable for bad receivers
// R13 - clear partner enable for bad transmitters
// R14 - hot-plug slots keep L0s disabled; code clears only the partner enable, not the port one
// R15 - links train first at the slow speed
// R16 - kick bits self-clear, one launch per write
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pls_defs.svh"
module pls_fw_ctl
  import pls_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  pls_link_if.ctl          link,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        partner_l0s_capable,
  output logic             partner_l0s_enable
);
  logic             awready_reg;
  logic             wready_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             arready_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;
  logic             aw_got_reg;
  logic             w_got_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic [5:2]       ctrl_reg;
  logic             go_speed_reg;
  logic             go_l0s_reg;
  logic [4:0]       status_reg;
  pls_state_t       state_reg;
  logic             req_reg;
  logic             we_reg;
  logic [7:0]       addr_reg;
  logic [31:0]      wd_reg;
  logic [31:0]      rd_reg;
  logic             partner_en_reg;
  logic             do_write;
  logic             busy;

  assign busy     = (state_reg != ST_IDLE);
  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

  // write address and data taken in either order
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PLS_RESP_OKAY;
    end else begin
      if (awvalid && awready_reg) begin
        aw_got_reg  <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_got_reg  <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= (aw_addr_reg == `PLS_AXI_OFS_CTRL) ? `PLS_RESP_OKAY : `PLS_RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // control register and start pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg     <= 4'h0;
      go_speed_reg <= 1'b0;
      go_l0s_reg   <= 1'b0;
    end else begin
      go_speed_reg <= 1'b0;
      go_l0s_reg   <= 1'b0;
      if (do_write && (aw_addr_reg == `PLS_AXI_OFS_CTRL) && w_strb_reg[0]) begin
        ctrl_reg     <= w_data_reg[`PLS_CTRL_TX_BAD:`PLS_CTRL_ALT_KICK];
        go_speed_reg <= w_data_reg[`PLS_CTRL_GO_SPEED] && !busy;
        go_l0s_reg   <= w_data_reg[`PLS_CTRL_GO_L0S] && !busy && !w_data_reg[`PLS_CTRL_GO_SPEED];
      end
    end
  end

  // read channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `PLS_RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      case (araddr)
        `PLS_AXI_OFS_CTRL: begin
          rdata_reg <= {26'h0, ctrl_reg, 2'h0};
          rresp_reg <= `PLS_RESP_OKAY;
        end
        `PLS_AXI_OFS_STATUS: begin
          rdata_reg <= {27'h0, status_reg[4:1], busy};
          rresp_reg <= `PLS_RESP_OKAY;
        end
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `PLS_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // sequencer: one port register access per state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg      <= ST_IDLE;
      req_reg        <= 1'b0;
      we_reg         <= 1'b0;
      addr_reg       <= 8'h00;
      wd_reg         <= 32'h00000000;
      rd_reg         <= 32'h00000000;
      status_reg     <= 5'h00;
      partner_en_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      if (go_speed_reg) begin
        status_reg[`PLS_ST_SPEED_ABANDON:`PLS_ST_SPEED_DONE] <= 2'h0;
        state_reg <= ST_CAP_RD;
      end else if (go_l0s_reg) begin
        status_reg[`PLS_ST_L0S_SKIPPED:`PLS_ST_L0S_DONE] <= 2'h0;
        // R14 hot-plug clears partner L0s enable, port enable untouched
        if (ctrl_reg[`PLS_CTRL_HOT_PLUG]) begin
          status_reg[`PLS_ST_L0S_SKIPPED] <= 1'b1;
          partner_en_reg <= 1'b0;
        end else begin
          state_reg <= ST_TMR_WR;
        end
      end
    end else if (!req_reg) begin
      req_reg <= 1'b1;
      case (state_reg)
        ST_CAP_RD: begin
          we_reg   <= 1'b0;
          addr_reg <= `PLS_OFS_SPEED_CFG;
        end
        // R3 R7 program target first
        ST_TGT_WR: begin
          we_reg   <= 1'b1;
          addr_reg <= `PLS_OFS_LINK_CTL_TWO;
          wd_reg   <= 32'(`PLS_TGT_GEN2) << `PLS_TGT_LSB;
        end
        // R4 R7 then hardware enable
        ST_HWEN_WR: begin
          we_reg   <= 1'b1;
          addr_reg <= `PLS_OFS_SPEED_CFG;
          wd_reg   <= 32'h1 << `PLS_BIT_FAST_EN;
        end
        ST_LC_RD, ST_LC2_RD: begin
          we_reg   <= 1'b0;
          addr_reg <= `PLS_OFS_LINK_CTL;
        end
        // R5 R6 R7 trigger last
        ST_KICK_WR: begin
          we_reg <= 1'b1;
          if (ctrl_reg[`PLS_CTRL_ALT_KICK]) begin
            addr_reg <= `PLS_OFS_SPEED_CFG;
            wd_reg   <= (32'h1 << `PLS_BIT_FAST_EN) | (32'h1 << `PLS_BIT_KICK);
          end else begin
            addr_reg <= `PLS_OFS_LINK_CTL;
            wd_reg   <= rd_reg | (32'h1 << `PLS_BIT_RETRAIN);
          end
        end
        // R8 timer before enable
        ST_TMR_WR: begin
          we_reg   <= 1'b1;
          addr_reg <= `PLS_OFS_IDLE_TIMER;
          wd_reg   <= 32'(`PLS_TMR_40NS) << `PLS_TMR_LSB;
        end
        // R9 R12 port enable or clear
        ST_L0S_WR: begin
          we_reg   <= 1'b1;
          addr_reg <= `PLS_OFS_LINK_CTL;
          wd_reg   <= ctrl_reg[`PLS_CTRL_RX_BAD] ? (rd_reg & ~(32'h1 << `PLS_BIT_L0S_EN))
                                                 : (rd_reg | (32'h1 << `PLS_BIT_L0S_EN));
        end
        default: req_reg <= 1'b0;
      endcase
    end else if (link.ack) begin
      req_reg <= 1'b0;
      rd_reg  <= link.rdata;
      case (state_reg)
        // R2 abandon without capability
        ST_CAP_RD: begin
          if (link.rdata[`PLS_BIT_PARTNER_FAST]) begin
            state_reg <= ST_TGT_WR;
          end else begin
            status_reg[`PLS_ST_SPEED_ABANDON] <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_TGT_WR:  state_reg <= ST_HWEN_WR;
        ST_HWEN_WR: state_reg <= ctrl_reg[`PLS_CTRL_ALT_KICK] ? ST_KICK_WR : ST_LC_RD;
        ST_LC_RD:   state_reg <= ST_KICK_WR;
        ST_KICK_WR: begin
          status_reg[`PLS_ST_SPEED_DONE] <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_TMR_WR:  state_reg <= ST_LC2_RD;
        ST_LC2_RD:  state_reg <= ST_L0S_WR;
        ST_L0S_WR: begin
          status_reg[`PLS_ST_L0S_DONE] <= 1'b1;
          // R10 R11 R13 partner enable
          partner_en_reg <= partner_l0s_capable && !ctrl_reg[`PLS_CTRL_TX_BAD];
          state_reg <= ST_IDLE;
        end
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  assign link.req           = req_reg;
  assign link.we            = we_reg;
  assign link.addr          = addr_reg;
  assign link.wdata         = wd_reg;
  assign awready            = awready_reg;
  assign wready             = wready_reg;
  assign bvalid             = bvalid_reg;
  assign bresp              = bresp_reg;
  assign arready            = arready_reg;
  assign rvalid             = rvalid_reg;
  assign rdata              = rdata_reg;
  assign rresp              = rresp_reg;
  assign partner_l0s_enable = partner_en_reg;
endmodule : pls_fw_ctl
`default_nettype wire

//--- tb/pls_link_checker.sv
// concurrent checks on the register link joining the two ends
`timescale 1ns/1ps
`default_nettype none
module pls_link_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        partner_fast_capable,
  input wire logic        speed_change_kick,
  input wire logic        fast_speed_hw_enable,
  input wire logic [3:0]  target_speed,
  input wire logic        tx_l0s_allow
);
  logic take;
  assign take = req && !ack;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_partner_fast_read: assert property (take && !we && addr == 8'hA4 |=> ack && rdata[24] == partner_fast_capable)
    else $error("partner fast bit read wrong");
  a_target_speed_set: assert property (take && we && addr == 8'h88 |=> ack && target_speed == $past(wdata[3:0]))
    else $error("target speed not taken");
  a_fast_enable_set: assert property (take && we && addr == 8'hA4 |=> fast_speed_hw_enable == $past(wdata[0]))
    else $error("fast enable not taken");
  a_retrain_kick: assert property (take && we && addr == 8'h68 && wdata[5] |=> speed_change_kick)
    else $error("retrain write gave no kick");
  a_alt_kick: assert property (take && we && addr == 8'hA4 && wdata[7] |=> speed_change_kick)
    else $error("alternate write gave no kick");
  a_kick_one_pulse: assert property (speed_change_kick |=> !speed_change_kick)
    else $error("kick longer than one cycle");
  a_kick_has_cause: assert property (speed_change_kick |->
    $past(take && we && ((addr == 8'h68 && wdata[5]) || (addr == 8'hA4 && wdata[7]))))
    else $error("kick without trigger write");
  a_retrain_reads_zero: assert property (take && !we && addr == 8'h68 |=> ack ##0 !rdata[5])
    else $error("retrain bit read back one");
  a_allow_follows: assert property (take && we && addr == 8'h68 |=> tx_l0s_allow == $past(wdata[0]))
    else $error("idle allow not taken");
  a_kick_after_setup: assert property (speed_change_kick |-> fast_speed_hw_enable && target_speed == 4'h2)
    else $error("kick before target and enable");
  a_slow_after_reset: assert property ($fell(rst) |-> target_speed == 4'h1 && !fast_speed_hw_enable)
    else $error("reset speed setup wrong");
endmodule : pls_link_checker
`default_nettype wire

//--- tb/tb_pcie_port_speed_and_l0s_control.sv
// testbench: both ends joined, driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_pcie_port_speed_and_l0s_control
  import pls_pkg::*;
;
  localparam logic [5:0] L_CTRL [5] = '{6'h0A, 6'h02, 6'h12, 6'h22, 6'h02};
  localparam logic [4:0] L_CAP      = 5'b01111;
  localparam logic [4:0] L_ALLOW    = 5'b11010;
  localparam logic [4:0] L_PEN      = 5'b00110;
  logic        clk_sys, rst, partner_fast_capable, tx_busy, partner_l0s_capable;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic        fast_speed_hw_enable, speed_change_kick, tx_l0s_allow, tx_l0s_enter, partner_l0s_enable;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, target_speed, tx_idle_entry_timer;
  logic [1:0]  bresp, rresp, rs;
  int          mismatches, checks_done, kicks, n;

  pls_link_if link ();
  pls_port_regs i_pls_port_regs (.clk_sys, .rst, .link(link), .partner_fast_capable, .tx_busy,
    .fast_speed_hw_enable, .target_speed, .speed_change_kick, .tx_idle_entry_timer, .tx_l0s_allow, .tx_l0s_enter);
  pls_fw_ctl i_pls_fw_ctl (.clk_sys, .rst, .link(link), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .partner_l0s_capable, .partner_l0s_enable);
  pls_link_checker i_pls_link_checker (.clk_sys, .rst, .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .partner_fast_capable, .speed_change_kick,
    .fast_speed_hw_enable, .target_speed, .tx_l0s_allow);

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (speed_change_kick === 1'b1) kicks <= kicks + 1;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // bounded wait step
  task automatic tick_out;
    n++;
    if (n > 300) begin
      mismatches++;
      conclude();
    end
  endtask : tick_out

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, wd;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      tick_out();
      if (awready && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      tick_out();
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  // start a sequence and poll status until not busy
  task automatic run(input logic [31:0] c);
    axw(8'h00, c, 4'hF);
    chk("start resp", rs, 2'h0);
    for (int i = 0; i < 40; i++) begin
      axr(8'h04);
      if (rd[0] === 1'b0) break;
    end
    chk("busy", rd[0], 1'b0);
    if (rd[0] !== 1'b0) conclude();
  endtask : run

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    partner_fast_capable = 1'b0;
    partner_l0s_capable = 1'b0;
    tx_busy = 1'b1;
    kicks = 0;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("target rst", target_speed, 4'h1);
    chk("fast rst", fast_speed_hw_enable, 1'b0);
    axr(8'h08);
    chk("unmapped resp", rs, 2'h2);
    run(32'h1);
    chk("abandon", rd[2:1], 2'b10);
    chk("no kick", kicks, 0);
    chk("target kept", target_speed, 4'h1);
    partner_fast_capable <= 1'b1;
    run(32'h1);
    chk("speed done", rd[2:1], 2'b01);
    chk("target", target_speed, 4'h2);
    chk("fast en", fast_speed_hw_enable, 1'b1);
    chk("retrain kicks", kicks, 1);
    run(32'h5);
    chk("alt kicks", kicks, 2);
    axr(8'h00);
    chk("ctrl readback", rd, 32'h00000004);
    axw(8'h00, 32'h0000003F, 4'hE);
    chk("masked resp", rs, 2'h0);
    axr(8'h00);
    chk("masked ignored", rd, 32'h00000004);
    axw(8'h08, 32'h00000000, 4'hF);
    chk("unmapped wr resp", rs, 2'h2);
    for (int i = 0; i < 5; i++) begin
      partner_l0s_capable <= L_CAP[i];
      run({26'h0, L_CTRL[i]});
      chk("l0s status", rd[4:3], (i == 0) ? 2'b10 : 2'b01);
      chk("allow", tx_l0s_allow, L_ALLOW[i]);
      chk("partner en", partner_l0s_enable, L_PEN[i]);
    end
    chk("timer", tx_idle_entry_timer, 4'h1);
    chk("no extra kick", kicks, 2);
    tx_busy <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      tick_out();
    end while (tx_l0s_enter !== 1'b1);
    chk("idle cycles", n inside {[5:8]}, 1'b1);
    tx_busy <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("busy clears", tx_l0s_enter, 1'b0);
    conclude();
  end
endmodule : tb_pcie_port_speed_and_l0s_control
`default_nettype wire
